// file: core/nvs_defines.vh
// Purpose: constants for the nonvolatile memory host controller
// Assumes: 100 MHz mclk, 10 ns period
// Notes: times are kept in their own units, cycle counts derive from them
`ifndef NVS_DEFINES_VH
`define NVS_DEFINES_VH

`define NVS_CLK_NS 10
// Unlock address sequence, lower 14 bits
`define NVS_SEQ0 14'h0E38
`define NVS_SEQ1 14'h31C7
`define NVS_SEQ2 14'h03E0
`define NVS_SEQ3 14'h3C1F
`define NVS_SEQ4 14'h303F
`define NVS_SEQ_STORE 14'h0FC0
`define NVS_SEQ_RECALL 14'h0C63
`define NVS_SEQ_LEN 3'h6
// Longest nonvolatile durations
`define NVS_STORE_MS 10
`define NVS_RECALL_US 20
`define NVS_PWRUP_US 550
`define NVS_STORE_CYC (`NVS_STORE_MS * 1000000 / `NVS_CLK_NS)
`define NVS_RECALL_CYC (`NVS_RECALL_US * 1000 / `NVS_CLK_NS)
`define NVS_PWRUP_CYC (`NVS_PWRUP_US * 1000 / `NVS_CLK_NS)
// Bus access phase timer loads in cycles; each phase lasts one cycle more
`define NVS_SETUP_CYC 4'h1
`define NVS_PULSE_CYC 4'h5
`define NVS_GAP_CYC 4'h2

`endif

// file: core/nvs_wait_timer.v
// Purpose: down counter that holds a busy level for a loaded cycle count
// Assumes: load is a one-cycle pulse
// Notes: reused for bus phases and nonvolatile busy windows
`timescale 1ns/1ns
`default_nettype none
module nvs_wait_timer #(
	parameter WIDTH = 24
) (
	// Clock and reset
	input wire mclk,
	input wire reset_n,
	// Control
	input wire load,
	input wire [WIDTH-1:0] count,
	// Status
	output wire busy
);
	reg [WIDTH-1:0] remain;

	// Load wins over the running count
	always @(posedge mclk) begin
		if (!reset_n) begin
			remain <= {WIDTH{1'b0}};
		end else if (load) begin
			remain <= count;
		end else if (remain != {WIDTH{1'b0}}) begin
			remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	assign busy = (remain != {WIDTH{1'b0}});
endmodule
`default_nettype wire

// file: core/nvs_host_ctrl.v
// Purpose: host controller driving an asynchronous nonvolatile SRAM
// Assumes: inputs synchronous to mclk; one command at a time
// Notes: issues reads, writes and the six-read store or recall unlock
//
// What this block does
// - Write enable high on reads, low on writes
// - Issue six unlock reads in fixed order
// - Store order ends at 0FC0, launches copy
// - Recall order ends at 0C63, launches transfer
// - Write enable stays high across unlock
// - One chip-select pulse per unlock read
// - Supply loss aborts the unlock sequence; no other access intervenes
`timescale 1ns/1ns
`default_nettype none
`include "nvs_defines.vh"
module nvs_host_ctrl #(
	parameter ADDR_W = 15,
	parameter DATA_W = 8,
	parameter TIMER_W = 24,
	parameter STORE_CYC = `NVS_STORE_CYC,
	parameter RECALL_CYC = `NVS_RECALL_CYC,
	parameter PWRUP_CYC = `NVS_PWRUP_CYC
) (
	// Clock and reset
	input wire mclk,
	input wire reset_n,
	// User command port
	input wire cmdValid,
	output wire cmdReady,
	input wire [1:0] cmdOp,
	input wire [ADDR_W-1:0] cmdAddr,
	input wire [DATA_W-1:0] cmdWdata,
	output reg rspValid,
	output reg [DATA_W-1:0] rspRdata,
	// Supply status
	input wire supplyOk,
	// Memory pins
	output reg memCs_n,
	output reg memWe_n,
	output reg memOe_n,
	output reg [ADDR_W-1:0] address_bus,
	input wire [DATA_W-1:0] data_bus_in,
	output reg [DATA_W-1:0] data_bus_out,
	output reg data_bus_oe
);
	// Command codes
	localparam [1:0] OP_READ = 2'h0;
	localparam [1:0] OP_WRITE = 2'h1;
	localparam [1:0] OP_STORE = 2'h2;
	localparam [1:0] OP_RECALL = 2'h3;
	// One-hot states
	localparam [5:0] S_PWRUP = 6'h01;
	localparam [5:0] S_IDLE = 6'h02;
	localparam [5:0] S_SETUP = 6'h04;
	localparam [5:0] S_PULSE = 6'h08;
	localparam [5:0] S_GAP = 6'h10;
	localparam [5:0] S_NVBUSY = 6'h20;

	reg [5:0] state;
	reg [5:0] next_state;
	reg [1:0] op;
	reg [2:0] step;
	reg supplyWas;
	reg tLoad;
	reg [TIMER_W-1:0] tCount;
	wire tBusy;

	// ****************************************************
	// Phase and busy timer
	// ****************************************************
	nvs_wait_timer #(.WIDTH(TIMER_W)) uTimer (
		.mclk(mclk),
		.reset_n(reset_n),
		.load(tLoad),
		.count(tCount),
		.busy(tBusy)
	);

	// ****************************************************
	// Unlock address table
	// ****************************************************
	// Top address bit is don't-care to the device, so drive it low
	function [ADDR_W-1:0] unlockAddr;
		input [2:0] idx;
		input isStore;
		begin
			case (idx)
				3'h0: unlockAddr = {{(ADDR_W-14){1'b0}}, `NVS_SEQ0};
				3'h1: unlockAddr = {{(ADDR_W-14){1'b0}}, `NVS_SEQ1};
				3'h2: unlockAddr = {{(ADDR_W-14){1'b0}}, `NVS_SEQ2};
				3'h3: unlockAddr = {{(ADDR_W-14){1'b0}}, `NVS_SEQ3};
				3'h4: unlockAddr = {{(ADDR_W-14){1'b0}}, `NVS_SEQ4};
				default: unlockAddr = isStore ?
					{{(ADDR_W-14){1'b0}}, `NVS_SEQ_STORE} :
					{{(ADDR_W-14){1'b0}}, `NVS_SEQ_RECALL};
			endcase
		end
	endfunction

	wire isUnlock = op[1];
	// Writes and stores refused while supply is low
	wire opAllowed = supplyOk || (cmdOp == OP_READ) || (cmdOp == OP_RECALL);
	assign cmdReady = (state == S_IDLE) && opAllowed;
	wire take = cmdValid && cmdReady;
	wire lastStep = (step == `NVS_SEQ_LEN - 3'h1);

	// ****************************************************
	// State sequencing
	// ****************************************************
	// Next-state choice
	always @* begin
		next_state = state;
		tLoad = 1'b0;
		tCount = {TIMER_W{1'b0}};
		case (state)
			S_PWRUP: begin
				// Wait out power-up recall once supply is good
				if (supplyOk && !supplyWas) begin
					tLoad = 1'b1;
					tCount = PWRUP_CYC[TIMER_W-1:0];
				end else if (supplyOk && !tBusy) begin
					next_state = S_IDLE;
				end
			end
			S_IDLE: begin
				if (take) begin
					next_state = S_SETUP;
					tLoad = 1'b1;
					tCount = {{(TIMER_W-4){1'b0}}, `NVS_SETUP_CYC};
				end
			end
			S_SETUP: begin
				if (!tBusy) begin
					next_state = S_PULSE;
					tLoad = 1'b1;
					tCount = {{(TIMER_W-4){1'b0}}, `NVS_PULSE_CYC};
				end
			end
			S_PULSE: begin
				if (!tBusy) begin
					next_state = S_GAP;
					tLoad = 1'b1;
					tCount = {{(TIMER_W-4){1'b0}}, `NVS_GAP_CYC};
				end
			end
			S_GAP: begin
				if (!tBusy) begin
					if (isUnlock && !lastStep) begin
						// Next unlock read follows with nothing between
						next_state = S_SETUP;
						tLoad = 1'b1;
						tCount = {{(TIMER_W-4){1'b0}}, `NVS_SETUP_CYC};
					end else if (isUnlock) begin
						next_state = S_NVBUSY;
						tLoad = 1'b1;
						tCount = (op == OP_STORE) ? STORE_CYC[TIMER_W-1:0] :
							RECALL_CYC[TIMER_W-1:0];
					end else begin
						next_state = S_IDLE;
					end
				end
			end
			S_NVBUSY: begin
				// Device ignores all access until done, so hold off
				if (!tBusy) begin
					next_state = S_IDLE;
				end
			end
			default: next_state = S_PWRUP;
		endcase
		// Supply loss forces a fresh power-up recall wait
		if (!supplyOk) begin
			next_state = S_PWRUP;
		end
	end

	// State, operation and step registers
	always @(posedge mclk) begin
		if (!reset_n) begin
			state <= S_PWRUP;
			op <= OP_READ;
			step <= 3'h0;
			supplyWas <= 1'b0;
		end else begin
			state <= next_state;
			supplyWas <= supplyOk;
			if (take) begin
				op <= cmdOp;
				step <= 3'h0;
			end else if (state == S_GAP && !tBusy && isUnlock && !lastStep) begin
				step <= step + 3'h1;
			end
		end
	end

	// ****************************************************
	// Pin drive
	// ****************************************************
	// Chip select low only in the pulse phase: one pulse per step
	always @(posedge mclk) begin
		if (!reset_n) begin
			memCs_n <= 1'b1;
			memWe_n <= 1'b1;
			memOe_n <= 1'b1;
			address_bus <= {ADDR_W{1'b0}};
			data_bus_out <= {DATA_W{1'b0}};
			data_bus_oe <= 1'b0;
		end else begin
			memCs_n <= !(next_state == S_PULSE);
			// Address moves only on entry to setup; a held setup must not step it on
			if (take) begin
				address_bus <= cmdOp[1] ? unlockAddr(3'h0, cmdOp == OP_STORE) : cmdAddr;
				data_bus_out <= cmdWdata;
			end else if (state == S_GAP && next_state == S_SETUP) begin
				address_bus <= unlockAddr(step + 3'h1, op == OP_STORE);
			end
			// Write enable set in setup so it is low before chip select
			memWe_n <= !((next_state == S_SETUP || next_state == S_PULSE) &&
				(take ? cmdOp == OP_WRITE : op == OP_WRITE));
			memOe_n <= !(next_state == S_PULSE && op == OP_READ);
			data_bus_oe <= (next_state == S_SETUP || next_state == S_PULSE ||
				next_state == S_GAP) && (take ? cmdOp == OP_WRITE : op == OP_WRITE);
		end
	end

	// ****************************************************
	// Response
	// ****************************************************
	// Read data sampled in the last pulse cycle; unlock ends answer after busy
	always @(posedge mclk) begin
		if (!reset_n) begin
			rspValid <= 1'b0;
			rspRdata <= {DATA_W{1'b0}};
		end else begin
			rspValid <= 1'b0;
			if (state == S_PULSE && !tBusy && op == OP_READ) begin
				rspRdata <= data_bus_in;
			end
			if (state == S_GAP && !tBusy && !isUnlock) begin
				rspValid <= 1'b1;
			end
			if (state == S_NVBUSY && !tBusy) begin
				rspValid <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: testbench/nvs_sram_model.sv
// Purpose: device model with unlock detector
// Assumes: pins from nvs_host_ctrl
// Notes: busy windows in ns
`timescale 1ns/1ns
`default_nettype none
module nvs_sram_model #(parameter STORE_NS = 200, RECALL_NS = 100) (
	// Memory pins
	input wire logic memCs_n,
	input wire logic memWe_n,
	input wire logic memOe_n,
	input wire logic [14:0] address_bus,
	input wire logic [7:0] data_bus_out,
	output logic [7:0] data_bus_in,
	// Supply and counts
	input wire logic supplyOk,
	output int stores,
	output int recalls
);
	logic [7:0] mem [0:32767];
	logic [13:0] seq [0:4] = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F};
	logic [7:0] last = 8'h00;
	logic busy = 1'b0;
	logic hiZ = 1'b0;
	int step = 0;
	// Undriven bus shows a stale pattern, never a kind constant
	assign data_bus_in = (!memCs_n && !memOe_n && memWe_n && !hiZ) ? mem[address_bus] : ~last;
	initial begin
		stores = 0;
		recalls = 0;
		foreach (mem[i]) mem[i] = i[7:0] ^ 8'h5A;
	end
	task automatic hold(input int len);
		busy = 1'b1;
		#len;
		busy = 1'b0;
	endtask
	// One step per chip-select fall; writes and busy reset the count
	always @(negedge memCs_n) begin
		last <= ~last ^ address_bus[7:0];
		hiZ = !memWe_n || busy;
		if (busy || !memWe_n) begin
			step = 0;
		end else if (step < 5) begin
			step = (address_bus[13:0] == seq[step]) ? step + 1 : 0;
		end else begin
			hiZ = 1'b1;
			if (address_bus[13:0] == 14'h0FC0 && supplyOk) begin
				stores++;
				fork hold(STORE_NS); join_none
			end else if (address_bus[13:0] == 14'h0C63) begin
				recalls++;
				fork hold(RECALL_NS); join_none
			end
			step = 0;
		end
	end
	// Level write, last value in the window wins
	always @(memCs_n, memWe_n, address_bus, data_bus_out)
		if (!memCs_n && !memWe_n && !busy && supplyOk)
			mem[address_bus] = data_bus_out;
endmodule
`default_nettype wire

// file: testbench/nvs_host_ctrl_monitor.sv
// Purpose: pin protocol checker
// Assumes: one clock domain
// Notes: bound to nvs_host_ctrl
`timescale 1ns/1ns
`default_nettype none
module nvs_host_ctrl_monitor #(parameter ADDR_W = 15) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Command side
	input wire logic cmdReady,
	input wire logic [1:0] cmdOp,
	input wire logic rspValid,
	input wire logic supplyOk,
	// Memory pins
	input wire logic memCs_n,
	input wire logic memWe_n,
	input wire logic memOe_n,
	input wire logic [ADDR_W-1:0] address_bus,
	input wire logic data_bus_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ****
	// Checks
	// ****
	a_read_we_high: assert property (!memOe_n |-> memWe_n) else $error("we low on read");
	a_write_oe_high: assert property (!memWe_n |-> memOe_n) else $error("oe low on write");
	a_rsp_single: assert property (rspValid |=> !rspValid) else $error("long rsp");
	a_ready_supply: assert property (cmdReady && (cmdOp == 2'h1 || cmdOp == 2'h2) |-> supplyOk)
		else $error("write taken low supply");
	a_busy_refuse: assert property (!memCs_n |-> !cmdReady) else $error("ready mid access");
	a_addr_hold: assert property (!memCs_n && $past(!memCs_n) |-> $stable(address_bus))
		else $error("address moved");
	a_cs_bounded: assert property ($fell(memCs_n) |-> ##[1:8] memCs_n) else $error("cs stuck");
	a_low_supply_we: assert property ($past(!supplyOk) |-> memWe_n) else $error("write low supply");
	a_rsp_idle_pins: assert property (rspValid |-> memCs_n && memWe_n) else $error("rsp busy");
	a_no_contention: assert property (data_bus_oe |-> memOe_n) else $error("bus contention");
	a_write_drives: assert property (!memWe_n |-> data_bus_oe) else $error("write undriven");
endmodule
bind nvs_host_ctrl nvs_host_ctrl_monitor #(.ADDR_W(ADDR_W)) u_mon (.mclk(mclk),
	.reset_n(reset_n), .cmdReady(cmdReady), .cmdOp(cmdOp), .rspValid(rspValid),
	.supplyOk(supplyOk), .memCs_n(memCs_n), .memWe_n(memWe_n), .memOe_n(memOe_n),
	.address_bus(address_bus), .data_bus_oe(data_bus_oe));
`default_nettype wire

// file: testbench/nvs_host_ctrl_test.sv
// Purpose: self-checking bench for nvs_host_ctrl
// Assumes: short nonvolatile counts
// Notes: inputs move at falling edges
`timescale 1ns/1ns
`default_nettype none
module nvs_host_ctrl_test;
	logic mclk = 0, reset_n = 0, cmdValid = 0, supplyOk = 0;
	logic [1:0] cmdOp = 2'h0;
	logic [14:0] cmdAddr = 15'h0;
	logic [7:0] cmdWdata = 8'h00, rspRdata, dIn, dOut;
	wire cmdReady, rspValid, memCs_n, memWe_n, memOe_n, dOe;
	wire [14:0] aBus;
	int stores, recalls, mismatches = 0, testsRun = 0, cyc;
	logic [31:0] seed = 32'h43CE147F;
	logic [7:0] refMem [int];
	always #5 mclk = ~mclk;
	nvs_host_ctrl #(.STORE_CYC(20), .RECALL_CYC(10), .PWRUP_CYC(30)) dut (.mclk(mclk),
		.reset_n(reset_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
		.cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .rspValid(rspValid), .rspRdata(rspRdata),
		.supplyOk(supplyOk), .memCs_n(memCs_n), .memWe_n(memWe_n), .memOe_n(memOe_n),
		.address_bus(aBus), .data_bus_in(dIn), .data_bus_out(dOut), .data_bus_oe(dOe));
	nvs_sram_model u_dev (.memCs_n(memCs_n), .memWe_n(memWe_n), .memOe_n(memOe_n),
		.address_bus(aBus), .data_bus_out(dOut), .data_bus_in(dIn), .supplyOk(supplyOk),
		.stores(stores), .recalls(recalls));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("tests=%0d mismatches=%0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Hold a request until taken, then wait a bounded time for the answer
	task automatic cmd(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d);
		cmdOp = op;
		cmdAddr = a;
		cmdWdata = d;
		cmdValid = 1'b1;
		cyc = 0;
		while (cmdReady !== 1'b1 && cyc < 200) begin
			@(negedge mclk);
			cyc++;
		end
		chk(32'(cyc < 200), 32'h1);
		@(negedge mclk);
		cmdValid = 1'b0;
		cyc = 0;
		while (rspValid !== 1'b1 && cyc < 300) begin
			@(negedge mclk);
			cyc++;
		end
		chk(32'(cyc < 300), 32'h1);
	endtask
	task automatic rd(input logic [14:0] a);
		cmd(2'h0, a, 8'h00);
		chk(rspRdata, refMem.exists(a) ? refMem[a] : a[7:0] ^ 8'h5A);
	endtask
	task automatic powerUp;
		int n;
		n = 0;
		supplyOk = 1'b1;
		while (cmdReady !== 1'b1 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		chk(32'(n >= 30 && n <= 40), 32'h1);
		$display("done power-up");
	endtask
	initial begin
		repeat (6) @(negedge mclk);
		reset_n = 1'b1;
		powerUp;
		// Random traffic, top address bit included
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			cmd(2'h1, seed[14:0], seed[22:15]);
			refMem[seed[14:0]] = seed[22:15];
			rd(seed[14:0]);
		end
		$display("done traffic");
		// Store and recall back to back, each followed by a read at once
		for (int k = 0; k < 4; k++) begin
			cmd(k[0] ? 2'h3 : 2'h2, 15'h0, 8'h00);
			chk(32'(cyc >= (k[0] ? 10 : 20)), 32'h1);
			chk(stores, (k + 2) / 2);
			chk(recalls, (k + 1) / 2);
			rd(seed[14:0]);
		end
		$display("done unlock");
		// Low supply refuses writes and stores while still idle; reads stay open
		supplyOk = 1'b0;
		cmdOp = 2'h1;
		#1;
		chk(cmdReady, 1'b0);
		cmdOp = 2'h2;
		#1;
		chk(cmdReady, 1'b0);
		cmdOp = 2'h0;
		#1;
		chk(cmdReady, 1'b1);
		@(negedge mclk);
		chk(cmdReady, 1'b0);
		chk(stores, 2);
		$display("done low supply");
		powerUp;
		rd(seed[14:0]);
		end_of_test;
	end
	// Run takes under a thousand cycles; allow over forty times that
	initial begin
		#400000;
		mismatches++;
		end_of_test;
	end
endmodule
`default_nettype wire
